// [verilog/prcp_parser.sv]
`timescale 1ns/1ps
module prcp_parser #(
    parameter int SEC_CYC = prcp_pkg::SEC_CYCLES
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire prcp_pkg::prcp_apb_req_t apb_in,
    output prcp_pkg::prcp_apb_rsp_t apb_out,
    input wire logic [4:0] bus_addr_in,
    input wire logic bus_secondary_in,
    input wire logic in_limit_in,
    input wire logic error_in,
    input wire logic eoc_in,
    output logic addressed_out,
    output logic srq_out,
    output logic zero_valve_out,
    output logic sensor_zero_out,
    output prcp_pkg::prcp_resp_t resp_fmt_out,
    output logic [1:0] term_sel_out
);
    import prcp_pkg::*;

    function automatic logic [7:0] to_upper(input logic [7:0] c);
        if (c >= CH_LA && c <= CH_LZ) begin
            return c & ~CASE_BIT;
        end
        return c;
    endfunction

    function automatic logic is_sep(input logic [7:0] c);
        return c == CH_SP || c == CH_COMMA || c == CH_SEMI ||
            c == CH_COLON || c == CH_CR || c == CH_LF;
    endfunction

    function automatic logic [31:0] scale(input logic [31:0] p,
                                          input logic [31:0] r);
        logic signed [64:0] prod;
        prod = $signed(p) * $signed({1'b0, r});
        return prod[FRAC_BITS+31:FRAC_BITS];
    endfunction

    prcp_pstate_t ps_r;
    prcp_zstate_t zs_r;
    logic [7:0] cmd_r;
    logic [23:0] mag_r;
    logic neg_r, dig_r;
    logic [31:0] setpt_r, plast_r, rate_r, wait_r, tare_r, maxrate_r;
    logic [31:0] frate_r [3];
    logic [31:0] ratio_r [N_SLOTS];
    logic [31:0] preset_r [N_SLOTS];
    logic [14:0] unitcfg_r;
    logic [4:0] custom_r, busaddr_r;
    logic [2:0] notation_r, srqsel_r, unitsel_r;
    logic [7:0] status_r, zdly_r;
    logic [1:0] term_r;
    logic tare_on_r, lock_r, ovs_low_r, err_r;
    logic [31:0] sec_cnt_r;
    logic [7:0] zsec_r;
    logic [31:0] prdata_r;
    logic pslverr_r;

    // bus strobes
    logic setup, wr, ch_vld, cs_rst, exec, bad_cmd, skip_pre;
    logic [7:0] ch;
    logic [31:0] val;
    logic [3:0] idx;
    logic [3:0] aidx;
    assign setup = apb_in.psel & ~apb_in.penable;
    assign wr = apb_in.psel & apb_in.penable & apb_in.pwrite;
    assign aidx = apb_in.paddr[5:2];
    assign ch_vld = wr && apb_in.paddr == A_RXCHR;
    assign ch = to_upper(apb_in.pwdata[7:0]); // RL1
    assign cs_rst = wr && apb_in.paddr == A_CTRL && apb_in.pwdata[C_CSRST];
    assign val = neg_r ? -{8'h00, mag_r} : {8'h00, mag_r};
    assign idx = mag_r[3:0];

    // finishing a command: any non-value character after the letter, except a space or equals sign before the first digit
    assign skip_pre = !dig_r && (ch == CH_SP || ch == CH_EQ); // RL2
    assign exec = ch_vld && ps_r == PS_VAL && !(ch >= CH_0 && ch <= CH_9)
        && !skip_pre && !(ch == CH_MINUS && !dig_r); // RL23

    // character parser
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ps_r <= PS_CMD;
            cmd_r <= 8'h00;
            mag_r <= 24'h000000;
            neg_r <= 1'b0;
            dig_r <= 1'b0;
        end else if (ch_vld) begin
            if (ps_r == PS_VAL && ch >= CH_0 && ch <= CH_9) begin
                mag_r <= 24'(mag_r * TEN + 24'(ch - CH_0));
                dig_r <= 1'b1;
            end else if (ps_r == PS_VAL && ch == CH_MINUS && !dig_r) begin
                neg_r <= 1'b1;
            end else if (is_sep(ch) || (ch == CH_EQ && !dig_r)) begin
                if (dig_r || ch != CH_SP) begin
                    ps_r <= (ch == CH_EQ) ? ps_r : PS_CMD; // RL3
                end
            end else begin
                ps_r <= PS_VAL;
                cmd_r <= ch;
                mag_r <= 24'h000000;
                neg_r <= 1'b0;
                dig_r <= 1'b0;
            end
        end
    end

    always_comb begin
        bad_cmd = 1'b0;
        case (cmd_r)
            "O", "P", "R", "M", "S", "T", "U", "V", "W", "/", "*", "J",
            "N", "I", "@", "B", "D", "F", "C": bad_cmd = 1'b0;
            default: bad_cmd = 1'b1;
        endcase
    end

    // pressure setpoint, ratio and preset
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            setpt_r <= 32'h00000000;
            plast_r <= 32'h00000000;
        end else if (exec) begin
            if (cmd_r == "P") begin
                setpt_r <= val;
                plast_r <= val;
            end else if (cmd_r == "/" && idx < 4'(N_SLOTS)) begin
                setpt_r <= scale(plast_r, ratio_r[idx]); // RL18
            end else if (cmd_r == "*" && idx < 4'(N_SLOTS)) begin
                setpt_r <= preset_r[idx]; // RL19
            end
        end
    end

    // slew rate and overshoot mode
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rate_r <= RST_MAXRATE;
            ovs_low_r <= 1'b0;
        end else if (exec && cmd_r == "V") begin
            if (neg_r && dig_r && mag_r != 24'h000000) begin
                rate_r <= maxrate_r; // RL8
                ovs_low_r <= 1'b0;
            end else if (mag_r == 24'h000000) begin
                rate_r <= maxrate_r; // RL7
                ovs_low_r <= 1'b1;
            end else begin
                rate_r <= (val > maxrate_r) ? maxrate_r : val; // RL6
                ovs_low_r <= 1'b1; // RL20
            end
        end else if (exec && cmd_r == "J" && idx < 4'h3) begin
            rate_r <= frate_r[idx[1:0]]; // RL17
        end
    end

    // command-set state with reset defaults
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            notation_r <= RST_NOTATION;
            srqsel_r <= RST_SRQ;
            status_r <= RST_STATUS;
            lock_r <= 1'b0;
            unitsel_r <= RST_UNITSEL;
            wait_r <= RST_WAIT;
        end else if (cs_rst) begin
            notation_r <= RST_NOTATION; // RL9
            srqsel_r <= RST_SRQ;
            status_r <= RST_STATUS;
            lock_r <= 1'b0;
            unitsel_r <= RST_UNITSEL;
            wait_r <= RST_WAIT;
        end else if (exec) begin
            case (cmd_r)
                "N": if (idx <= 4'h4) notation_r <= idx[2:0];
                "I": if (idx <= 4'h7) srqsel_r <= idx[2:0];
                "@": status_r <= mag_r[7:0];
                "R": lock_r <= (idx != 4'h0);
                "M": lock_r <= 1'b0;
                "S": if (idx <= 4'h4) unitsel_r <= idx[2:0];
                "W": wait_r <= val; // RL21
                default: ;
            endcase
        end
    end

    // tare and custom unit slot
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tare_r <= 32'h00000000;
            tare_on_r <= 1'b0;
            custom_r <= RST_S3_UNIT;
        end else if (exec) begin
            if (cmd_r == "B") begin
                tare_r <= val;
            end else if (cmd_r == "T") begin
                tare_on_r <= (idx == 4'h1); // RL15
            end else if (cmd_r == "U" && mag_r[4:0] != 5'h00 &&
                         mag_r <= 24'(UNIT_MAX)) begin
                custom_r <= mag_r[4:0]; // RL14
            end
        end
    end

    // parse error flag, new error wins over clear
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            err_r <= 1'b0;
        end else if (exec && bad_cmd) begin
            err_r <= 1'b1;
        end else if (wr && apb_in.paddr == A_STAT && apb_in.pwdata[S_ERR]) begin
            err_r <= 1'b0;
        end
    end

    // operator configuration
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            maxrate_r <= RST_MAXRATE;
            unitcfg_r <= 15'h0000;
            term_r <= 2'h0;
            busaddr_r <= RST_BUSADDR;
            zdly_r <= ZERO_DELAY_S; // RL5
            for (int i = 0; i < 3; i++) frate_r[i] <= 32'h00000000;
            for (int i = 0; i < N_SLOTS; i++) begin
                ratio_r[i] <= 32'h00000000;
                preset_r[i] <= 32'h00000000;
            end
        end else if (wr) begin
            case (apb_in.paddr)
                A_MAXRATE: maxrate_r <= apb_in.pwdata;
                A_FRATE0: frate_r[0] <= apb_in.pwdata;
                A_FRATE1: frate_r[1] <= apb_in.pwdata;
                A_FRATE2: frate_r[2] <= apb_in.pwdata;
                A_UNITCFG: unitcfg_r <= apb_in.pwdata[14:0]; // RL16
                A_CTRL: begin
                    term_r <= apb_in.pwdata[C_TERM_LO +: 2]; // RL13
                    busaddr_r <= apb_in.pwdata[C_ADDR_LO +: 5];
                    if (apb_in.pwdata[C_ZDLY_LO +: 8] >= ZERO_DELAY_S) begin
                        zdly_r <= apb_in.pwdata[C_ZDLY_LO +: 8]; // RL5
                    end
                end
                default: begin
                    if (aidx < 4'(N_SLOTS) &&
                        apb_in.paddr[7:6] == A_RATIO_HI) begin
                        ratio_r[aidx] <= apb_in.pwdata;
                    end
                    if (aidx < 4'(N_SLOTS) &&
                        apb_in.paddr[7:6] == A_PRESET_HI) begin
                        preset_r[aidx] <= apb_in.pwdata;
                    end
                end
            endcase
        end
    end

    // zeroing sequence: valve, delay in seconds, sensor zero
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            zs_r <= ZS_IDLE;
            sec_cnt_r <= 32'h00000000;
            zsec_r <= 8'h00;
        end else begin
            case (zs_r)
                ZS_IDLE: if (exec && cmd_r == "O" && idx == 4'h1) begin
                    zs_r <= ZS_WAIT; // RL4
                    sec_cnt_r <= 32'h00000000;
                    zsec_r <= 8'h00;
                end
                ZS_WAIT: begin
                    if (sec_cnt_r == 32'(SEC_CYC - 1)) begin
                        sec_cnt_r <= 32'h00000000;
                        zsec_r <= zsec_r + 8'h01;
                        if (zsec_r + 8'h01 >= zdly_r) zs_r <= ZS_FIRE; // RL4
                    end else begin
                        sec_cnt_r <= sec_cnt_r + 32'h00000001;
                    end
                end
                default: zs_r <= ZS_IDLE;
            endcase
        end
    end

    // outputs from state
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            zero_valve_out <= 1'b0;
            sensor_zero_out <= 1'b0;
            srq_out <= 1'b0;
            addressed_out <= 1'b0;
        end else begin
            zero_valve_out <= (zs_r == ZS_WAIT); // RL4
            sensor_zero_out <= (zs_r == ZS_FIRE);
            srq_out <= (in_limit_in & srqsel_r[0]) | // RL22
                (error_in & srqsel_r[1]) | (eoc_in & srqsel_r[2]);
            addressed_out <= !bus_secondary_in && // RL12
                bus_addr_in == busaddr_r;
        end
    end

    // response field selection per notation
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            resp_fmt_out <= '0;
        end else begin
            case (notation_r)
                3'h0: resp_fmt_out <= 7'b1110010; // RL10
                3'h1: resp_fmt_out <= 7'b1000010; // RL10
                3'h2: resp_fmt_out <= 7'b0111000; // RL10
                3'h3: resp_fmt_out <= 7'b0000110; // RL11
                3'h4: resp_fmt_out <= 7'b0000001;
                default: resp_fmt_out <= '0;
            endcase
        end
    end
    assign term_sel_out = term_r; // RL13

    // current unit number for status readback
    logic [4:0] unit_cur;
    always_comb begin
        case (unitsel_r)
            3'h0: unit_cur = unitcfg_r[4:0]; // RL16
            3'h1: unit_cur = unitcfg_r[9:5];
            3'h2: unit_cur = unitcfg_r[14:10];
            3'h4: unit_cur = custom_r; // RL14
            default: unit_cur = RST_S3_UNIT;
        endcase
    end

    // read data captured in setup phase, no wait states
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
            case (apb_in.paddr)
                A_RXCHR: prdata_r <= 32'h00000000;
                A_CTRL: prdata_r <= {16'h0000, zdly_r, 1'b0, busaddr_r, term_r};
                A_STAT: prdata_r <= {16'h0000, err_r, unit_cur, srqsel_r,
                    notation_r, ovs_low_r, lock_r, tare_on_r,
                    zs_r != ZS_IDLE};
                A_SETPT: prdata_r <= setpt_r;
                A_RATE: prdata_r <= rate_r;
                A_WAIT: prdata_r <= wait_r;
                A_TARE: prdata_r <= tare_r;
                A_MAXRATE: prdata_r <= maxrate_r;
                A_FRATE0: prdata_r <= frate_r[0];
                A_FRATE1: prdata_r <= frate_r[1];
                A_FRATE2: prdata_r <= frate_r[2];
                A_UNITCFG: prdata_r <= {17'h00000, unitcfg_r};
                A_MISC: prdata_r <= {19'h00000, custom_r, status_r};
                default: begin
                    if (aidx < 4'(N_SLOTS) &&
                        apb_in.paddr[7:6] == A_RATIO_HI) begin
                        prdata_r <= ratio_r[aidx];
                    end else if (aidx < 4'(N_SLOTS) &&
                                 apb_in.paddr[7:6] == A_PRESET_HI) begin
                        prdata_r <= preset_r[aidx];
                    end else begin
                        pslverr_r <= 1'b1;
                    end
                end
            endcase
        end
    end

    assign apb_out.prdata = prdata_r;
    assign apb_out.pslverr = pslverr_r & apb_in.psel & apb_in.penable;
    assign apb_out.pready = 1'b1;
endmodule

// [pkg/prcp_pkg.sv]
// Operation
// RL1: command letters match regardless of upper or lower case
// RL2: spaces and equals signs between letter and value are skipped
// RL3: spaces, commas, semicolons and colons around commands only separate
// RL4: zero command opens valve, waits zero delay, then zeroes sensor
// RL5: zero delay defaults to five seconds, operator may lengthen it
// RL6: positive rate applied up to maximum rate, overshoot low
// RL7: zero rate selects maximum rate, overshoot low
// RL8: negative rate selects maximum rate, overshoot normal
// RL9: command-set reset restores notation, request, status, lock, unit, wait
// RL10: notation one gives value and suffix; zero and two add state fields (two here gives state fields without value or suffix)
// RL11: notation three gives in-limit status and optional suffix only
// RL12: bus answers primary address only, never secondary addresses
// RL13: terminator selectable among four end-of-message forms
// RL14: custom unit command sets fifth slot, live if that slot selected
// RL15: tare on uses stored tare value; tare off disables tare
// RL16: first three unit selections map to configured unit choices
// RL17: three preset-rate commands apply three configured rates
// RL18: ratio commands scale last pressure setpoint by stored fraction
// RL19: preset commands select one of twelve stored preset values
// RL20: slew command with value also selects low overshoot mode
// RL21: wait command stores in-limit settling time
// RL22: request code picks in-limit, error, conversion events; top code all
// RL23: commands execute strictly in arrival order
package prcp_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int NS_PER_SEC = 1000000000;
    localparam int SEC_CYCLES = NS_PER_SEC / CLK_PERIOD_NS;
    localparam logic [7:0] ZERO_DELAY_S = 8'h05;
    // register byte offsets
    localparam logic [7:0] A_RXCHR = 8'h00;
    localparam logic [7:0] A_CTRL = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_SETPT = 8'h0c;
    localparam logic [7:0] A_RATE = 8'h10;
    localparam logic [7:0] A_WAIT = 8'h14;
    localparam logic [7:0] A_TARE = 8'h18;
    localparam logic [7:0] A_MAXRATE = 8'h1c;
    localparam logic [7:0] A_FRATE0 = 8'h20;
    localparam logic [7:0] A_FRATE1 = 8'h24;
    localparam logic [7:0] A_FRATE2 = 8'h28;
    localparam logic [7:0] A_UNITCFG = 8'h2c;
    localparam logic [7:0] A_MISC = 8'h30;
    localparam logic [1:0] A_RATIO_HI = 2'h1;
    localparam logic [1:0] A_PRESET_HI = 2'h2;
    localparam int N_SLOTS = 12;
    // ctrl fields
    localparam int C_TERM_LO = 0;
    localparam int C_ADDR_LO = 2;
    localparam int C_ZDLY_LO = 8;
    localparam int C_CSRST = 16;
    // stat fields
    localparam int S_ERR = 15;
    // reset values
    localparam logic [2:0] RST_NOTATION = 3'h0;
    localparam logic [2:0] RST_SRQ = 3'h0;
    localparam logic [7:0] RST_STATUS = 8'h01;
    localparam logic [2:0] RST_UNITSEL = 3'h0;
    localparam logic [31:0] RST_WAIT = 32'h00000002;
    localparam logic [4:0] RST_S3_UNIT = 5'h10;
    localparam logic [4:0] UNIT_MAX = 5'h17;
    localparam logic [4:0] RST_BUSADDR = 5'h01;
    localparam logic [31:0] RST_MAXRATE = 32'h00000064;
    localparam int FRAC_BITS = 16;
    // characters
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_EQ = 8'h3d;
    localparam logic [7:0] CH_COMMA = 8'h2c;
    localparam logic [7:0] CH_SEMI = 8'h3b;
    localparam logic [7:0] CH_COLON = 8'h3a;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_MINUS = 8'h2d;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_9 = 8'h39;
    localparam logic [7:0] CH_LA = 8'h61;
    localparam logic [7:0] CH_LZ = 8'h7a;
    localparam logic [7:0] CASE_BIT = 8'h20;
    localparam logic [3:0] TEN = 4'ha;

    typedef enum logic [0:0] {
        PS_CMD = 1'b0,
        PS_VAL = 1'b1
    } prcp_pstate_t;

    typedef enum logic [1:0] {
        ZS_IDLE = 2'b00,
        ZS_WAIT = 2'b01,
        ZS_FIRE = 2'b10
    } prcp_zstate_t;

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } prcp_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } prcp_apb_rsp_t;

    // which fields the talk response carries
    typedef struct packed {
        logic value_en;
        logic remloc_en;
        logic state_en;
        logic cfg_en;
        logic inlimit_en;
        logic suffix_en;
        logic full_en;
    } prcp_resp_t;
endpackage

// [testbench/prcp_chk.sv]
`timescale 1ns/1ps
module prcp_chk
    import prcp_pkg::*;
#(
    parameter int SEC_CYC = 10
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire prcp_pkg::prcp_apb_req_t apb_in,
    input wire prcp_pkg::prcp_apb_rsp_t apb_out,
    input wire logic [4:0] bus_addr_in,
    input wire logic bus_secondary_in,
    input wire logic in_limit_in,
    input wire logic error_in,
    input wire logic eoc_in,
    input wire logic addressed_out,
    input wire logic srq_out,
    input wire logic zero_valve_out,
    input wire logic sensor_zero_out,
    input wire prcp_pkg::prcp_resp_t resp_fmt_out,
    input wire logic [1:0] term_sel_out
);
    logic [31:0] vcnt_r;
    logic wr_any;
    // write access edge
    assign wr_any = apb_in.psel && apb_in.penable && apb_in.pwrite;
    // valve-open cycle count
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            vcnt_r <= '0;
        end else if (sensor_zero_out) begin
            vcnt_r <= '0;
        end else if (zero_valve_out) begin
            vcnt_r <= vcnt_r + 32'h1;
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    a_sec_no_addr: assert property (bus_secondary_in |=> !addressed_out)
        else $error("addressed by secondary");
    a_zero_one_cyc: assert property (sensor_zero_out |=> !sensor_zero_out)
        else $error("zero pulse too long");
    a_valve_first: assert property (sensor_zero_out |-> $past(zero_valve_out))
        else $error("zero without valve");
    a_zero_delay: assert property (sensor_zero_out |-> vcnt_r >= 5 * SEC_CYC)
        else $error("zero delay short");
    a_valve_cause: assert property ($rose(zero_valve_out) |->
        $past(wr_any) || $past(wr_any, 2) || $past(wr_any, 3))
        else $error("valve opened unprompted");
    a_srq_quiet: assert property (
        !(in_limit_in || error_in || eoc_in) |=> !srq_out)
        else $error("request without event");
    a_fmt_legal: assert property ($past(rst_n_in) |-> resp_fmt_out inside {
        7'h72, 7'h42, 7'h38, 7'h06, 7'h01}) else $error("bad format");
    a_term_write: assert property ($changed(term_sel_out) |->
        $past(wr_any && apb_in.paddr == A_CTRL)) else $error("term moved");
    c_zero: cover property (sensor_zero_out);
    c_srq: cover property (srq_out);
    c_addr: cover property (addressed_out);
endmodule
bind prcp_parser prcp_chk #(.SEC_CYC(SEC_CYC)) u_chk(.*);

// [testbench/prcp_host.sv]
`timescale 1ns/1ps
module prcp_host
    import prcp_pkg::*;
(
    input wire logic mclk_in,
    input wire prcp_pkg::prcp_apb_rsp_t rsp_in,
    output prcp_pkg::prcp_apb_req_t req_out
);
    // bus idle from time zero
    initial req_out = '0;
    // one apb transfer; called right after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic err);
        req_out <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w,
            pwdata: d};
        @(posedge mclk_in);
        req_out.penable <= 1'b1;
        do @(posedge mclk_in); while (rsp_in.pready !== 1'b1);
        rd = rsp_in.prdata;
        err = rsp_in.pslverr;
        req_out.psel <= 1'b0;
        req_out.penable <= 1'b0;
        @(posedge mclk_in);
    endtask
    // text command, one character per write
    task automatic send(input string s);
        logic [31:0] rd;
        logic err;
        for (int i = 0; i < s.len(); i++) begin
            xfer(1'b1, A_RXCHR, {24'h0, s[i]}, rd, err);
        end
    endtask
endmodule

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb;
    import prcp_pkg::*;
    localparam int SC = 10;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [4:0] bus_addr_in = 5'h01;
    logic bus_secondary_in = 1'b0;
    logic in_limit_in = 1'b0, error_in = 1'b0, eoc_in = 1'b0;
    prcp_apb_req_t apb_in;
    prcp_apb_rsp_t apb_out;
    logic addressed_out, srq_out, zero_valve_out, sensor_zero_out;
    prcp_resp_t resp_fmt_out;
    logic [1:0] term_sel_out;
    int n_mismatch = 0, n_tests = 0, n_pulse = 0, c;
    logic [31:0] rd;
    logic err;
    logic [6:0] fmt_tab [5] = '{7'h72, 7'h42, 7'h38, 7'h06, 7'h01};
    // 40 mhz clock
    always #12.5 mclk_in = ~mclk_in;
    // zero pulses seen
    always @(posedge mclk_in) if (sensor_zero_out === 1'b1) n_pulse++;
    prcp_parser #(.SEC_CYC(SC)) u_dut(.*);
    prcp_host u_host(.mclk_in(mclk_in), .rsp_in(apb_out), .req_out(apb_in));
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, rd, err);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a,
        input logic [31:0] m, e);
        u_host.xfer(1'b0, a, 32'h0, rd, err);
        chk(nm, rd & m, e);
    endtask
    task automatic t_reset();
        rdc("ctrl", A_CTRL, 32'h0000fffc, 32'h00000504);
        rdc("wait", A_WAIT, 32'hffffffff, 32'h00000002);
        rdc("status code", A_MISC, 32'h000000ff, 32'h00000001);
        rdc("stat", A_STAT, 32'h000003f4, 32'h0);
        rdc("unmapped", 8'h3c, 32'hffffffff, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
        $display("test reset done");
    endtask
    task automatic t_parse();
        u_host.send(" p = 12;");
        rdc("setpoint", A_SETPT, 32'hffffffff, 32'h0000000c);
        u_host.send(":P5,p 6 ");
        rdc("setpoint", A_SETPT, 32'hffffffff, 32'h00000006);
        wr(A_MAXRATE, 32'h00000032);
        u_host.send("V20 ");
        rdc("rate", A_RATE, 32'hffffffff, 32'h00000014);
        rdc("overshoot", A_STAT, 32'h00000008, 32'h00000008);
        u_host.send("v80;V-3 ");
        rdc("rate", A_RATE, 32'hffffffff, 32'h00000032);
        rdc("overshoot", A_STAT, 32'h00000008, 32'h0);
        u_host.send("V0 w=7 ");
        rdc("rate", A_RATE, 32'hffffffff, 32'h00000032);
        rdc("overshoot", A_STAT, 32'h00000008, 32'h00000008);
        rdc("wait", A_WAIT, 32'hffffffff, 32'h00000007);
        $display("test parse done");
    endtask
    task automatic t_units();
        wr(A_UNITCFG, 32'h000024a3);
        u_host.send("S1 B25 T1 ");
        rdc("unit", A_STAT, 32'h00007c02, 32'h00001402);
        rdc("tare", A_TARE, 32'hffffffff, 32'h00000019);
        u_host.send("S4 U12 T0 ");
        rdc("unit", A_STAT, 32'h00007c02, 32'h00003000);
        rdc("slot", A_MISC, 32'h00001f00, 32'h00000c00);
        $display("test units done");
    endtask
    task automatic t_presets();
        for (int i = 0; i < 3; i++) begin
            wr(A_FRATE0 + 8'(4 * i), 32'(11 * (i + 1)));
            u_host.send($sformatf("J%0d ", i));
            rdc("j rate", A_RATE, 32'hffffffff, 32'(11 * (i + 1)));
        end
        wr(8'h4c, 32'h00008000);
        wr(8'hac, 32'h0000004d);
        u_host.send("P40 /3 ");
        rdc("ratio", A_SETPT, 32'hffffffff, 32'h00000014);
        u_host.send("*11 ");
        rdc("preset", A_SETPT, 32'hffffffff, 32'h0000004d);
        u_host.send("/3 ");
        rdc("ratio", A_SETPT, 32'hffffffff, 32'h00000014);
        $display("test presets done");
    endtask
    task automatic t_notation();
        for (int i = 0; i < 5; i++) begin
            u_host.send($sformatf("N%0d ", i));
            rdc("notation", A_STAT, 32'h00000070, 32'(i << 4));
            chk("format", 32'(resp_fmt_out), 32'(fmt_tab[i]));
        end
        $display("test notation done");
    endtask
    task automatic t_events();
        u_host.send("I2 ");
        error_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        chk("srq error", 32'(srq_out), 32'h1);
        error_in <= 1'b0;
        in_limit_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        chk("srq masked", 32'(srq_out), 32'h0);
        u_host.send("I7 ");
        repeat (2) @(posedge mclk_in);
        chk("srq all", 32'(srq_out), 32'h1);
        in_limit_in <= 1'b0;
        bus_secondary_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        chk("addressed sec", 32'(addressed_out), 32'h0);
        bus_secondary_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        chk("addressed", 32'(addressed_out), 32'h1);
        $display("test events done");
    endtask
    task automatic t_zero();
        for (int t = 0; t < 4; t++) begin
            wr(A_CTRL, 32'h00000504 | 32'(t));
            chk("term", 32'(term_sel_out), 32'(t));
        end
        wr(A_CTRL, 32'h00000304);
        rdc("zero delay", A_CTRL, 32'h0000ff00, 32'h00000500);
        u_host.send("O1 ");
        c = 0;
        while (zero_valve_out !== 1'b1 && c < 20) begin
            @(posedge mclk_in);
            c++;
        end
        c = 0;
        while (zero_valve_out === 1'b1 && c < 200) begin
            @(posedge mclk_in);
            c++;
        end
        chk("valve cycles", 32'(c), 32'(5 * SC));
        repeat (2) @(posedge mclk_in);
        chk("zero pulses", 32'(n_pulse), 32'h1);
        $display("test zero done");
    endtask
    task automatic t_csreset();
        u_host.send("N3 R1 I5 W9 ");
        wr(A_CTRL, 32'h00010504);
        rdc("stat", A_STAT, 32'h000003f4, 32'h0);
        rdc("wait", A_WAIT, 32'hffffffff, 32'h00000002);
        chk("format", 32'(resp_fmt_out), 32'h00000072);
        $display("test command reset done");
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge mclk_in);
        n_mismatch++;
        final_report();
    end
    // reset, then scenarios
    initial begin
        repeat (8) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        @(posedge mclk_in);
        t_reset();
        t_parse();
        t_units();
        t_presets();
        t_notation();
        t_events();
        t_zero();
        t_csreset();
        final_report();
    end
endmodule
